// ==== pkg/xport_defines.svh ====
`ifndef XPORT_DEFINES_SVH
`define XPORT_DEFINES_SVH
// register offsets on the configuration port
`define OFF_LOGICAL_LANE_SETTING 12'h110
`define OFF_PHYSICAL_LANE_POWERDOWN 12'h201
`define OFF_LINK_DEVICE_IDENTIFIER 12'h450
`define OFF_LINK_BANK_IDENTIFIER 12'h451
`define OFF_LANE_ZERO_IDENTIFIER 12'h452
`define OFF_LANE_COUNT_MINUS_ONE 12'h453
`define OFF_OCTETS_PER_FRAME_MINUS_ONE 12'h454
`define OFF_FRAMES_PER_MULTIFRAME_MINUS_ONE 12'h455
`define OFF_CONVERTER_COUNT_MINUS_ONE 12'h456
`define OFF_RESOLUTION_MINUS_ONE 12'h457
`define OFF_SAMPLE_BITS_MINUS_ONE 12'h458
`define OFF_SAMPLES_AND_VERSION 12'h459
`define OFF_HIGH_DENSITY_FLAG 12'h45a
`define OFF_INTERP_SELECT 12'h460
`define OFF_XPORT_STATUS 12'h461
`define OFF_PCLK_PERIOD 12'h462
// field positions
`define LANE_SETTING_MSB 7
`define LANE_SETTING_LSB 4
`define VERSION_MSB 7
`define VERSION_LSB 5
`define HD_BIT 7
// fixed link values and reset values
`define FIXED_K 8'd32
`define FIXED_N 8'd16
`define FIXED_NP 8'd16
`define FIXED_M 8'd2
`define VERSION_B 3'h1
`define RST_POWERDOWN 8'h00
`define RST_ZERO 8'h00
`define OCTETS_PER_PCLK 4
`endif

// ==== pkg/xport_pkg.sv ====
package xport_pkg;
    typedef enum logic [2:0] {
        INTERP_6X,
        INTERP_8X,
        INTERP_12X,
        INTERP_16X,
        INTERP_24X
    } interp_t;
    typedef enum logic {
        DS_HUNT,
        DS_ALIGNED
    } deskew_state_t;
endpackage

// ==== pkg/xport_link_if.sv ====
`timescale 1ns/10ps
// eight lanes, four octets per lane per processing-clock cycle
interface xport_link_if;
    logic [7:0] lane_valid;
    logic [7:0] lane_start;
    logic [255:0] lane_data;
    logic [7:0] lane_powerdown;
    logic link_ready;
    modport transmitter (
        output lane_valid,
        output lane_start,
        output lane_data,
        input lane_powerdown,
        input link_ready
    );
    modport receiver (
        input lane_valid,
        input lane_start,
        input lane_data,
        output lane_powerdown,
        output link_ready
    );
endinterface

// ==== rtl/mode_check.sv ====
`timescale 1ns/10ps
`include "xport_defines.svh"
// decides whether interpolation and lane count form a supported mode
module mode_check (
    input wire xport_pkg::interp_t interp,
    input wire logic [3:0] lanes,
    input wire logic [7:0] lanes_m1,
    input wire logic [7:0] f_m1,
    input wire logic [7:0] s_m1,
    input wire logic [7:0] hd,
    output logic mode_ok,
    output logic [7:0] pclk_period,
    output logic [2:0] frame_octets
);
    logic lane_ok;
    logic layout_ok;
    logic [2:0] f_val;
    logic [1:0] s_val;
    logic [4:0] interp_n;
    // lane counts per interpolation
    always_comb begin
        case (interp)
            xport_pkg::INTERP_6X: lane_ok = lanes inside {4'd8, 4'd6, 4'd4, 4'd3}; // RULE_01
            xport_pkg::INTERP_8X,
            xport_pkg::INTERP_12X: lane_ok = lanes inside {4'd8, 4'd6, 4'd4, 4'd3, 4'd2}; // RULE_01
            xport_pkg::INTERP_16X,
            xport_pkg::INTERP_24X: lane_ok = lanes inside {4'd8, 4'd6, 4'd4, 4'd3, 4'd2, 4'd1};
            default: lane_ok = 1'b0;
        endcase
    end
    // frame layout per lane count
    always_comb begin
        f_val = 3'd0;
        s_val = 2'd0;
        case (lanes)
            4'd8: begin f_val = 3'd1; s_val = 2'd2; end // RULE_03
            4'd4: begin f_val = 3'd1; s_val = 2'd1; end
            4'd2: begin f_val = 3'd2; s_val = 2'd1; end
            4'd1: begin f_val = 3'd4; s_val = 2'd1; end
            4'd6: begin f_val = 3'd2; s_val = 2'd3; end
            4'd3: begin f_val = 3'd4; s_val = 2'd3; end
            default: begin f_val = 3'd0; s_val = 2'd0; end
        endcase
    end
    always_comb begin
        case (interp)
            xport_pkg::INTERP_6X: interp_n = 5'd6;
            xport_pkg::INTERP_8X: interp_n = 5'd8;
            xport_pkg::INTERP_12X: interp_n = 5'd12;
            xport_pkg::INTERP_16X: interp_n = 5'd16;
            default: interp_n = 5'd24;
        endcase
    end
    // programmed fields must match the layout, minus one each
    assign layout_ok = (lanes_m1 == 8'({4'd0, lanes} - 8'd1))
        && (f_m1 == 8'(f_val - 3'd1)) && (s_m1 == 8'(s_val - 2'd1))
        && (hd[`HD_BIT] == (f_val == 3'd1)); // RULE_05 RULE_06
    assign mode_ok = lane_ok && layout_ok; // RULE_16
    // widen before the product so that 24 times 8 keeps all its bits
    assign pclk_period = 8'({3'd0, interp_n} * {4'd0, lanes}); // RULE_04
    assign frame_octets = f_val;
endmodule

// ==== rtl/xport_rx.sv ====
`timescale 1ns/10ps
`include "xport_defines.svh"
// Operation
// RULE_01: lane counts allowed per interpolation factor
// RULE_02: fixed K=32, N=NP=16, no control bits
// RULE_03: two converters, F and S by lanes
// RULE_04: pclk period is interpolation times lanes
// RULE_05: software writes parameters as value minus one
// RULE_06: high-density bit set only when F=1
// RULE_07: device and bank identifiers match transmitter; the code only stores them and compares neither
// RULE_08: lane zero identifier matches transmitter; the code only stores its low five bits and compares nothing
// RULE_09: version field matches transmitter, 1 is B
// RULE_10: deframe lanes into converter samples
// RULE_11: deskew logical lanes automatically once configured
// RULE_12: lane setting bits enable logical lanes
// RULE_13: powerdown bit one disables physical lane
// RULE_14: four octets per lane per pclk
// RULE_15: frames become dac samples per parameters
// RULE_16: unsupported modes never reach the deframer
module xport_rx #(
    parameter int LANES = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic [15:0] dac0_sample,
    output logic [15:0] dac1_sample,
    output logic sample_valid,
    output logic config_valid,
    xport_link_if.receiver link
);
    generate
        if (LANES != 8) begin : g_lane_check
            $error("xport_rx serves eight lanes only");
        end
    endgenerate
    logic [7:0] lane_setting_reg, powerdown_reg, did_reg, bid_reg, lane_zero_identifier_reg;
    logic [7:0] l_m1_reg, f_m1_reg, k_m1_reg, m_m1_reg, n_m1_reg, np_m1_reg;
    logic [7:0] sv_reg, hd_reg, interp_reg;
    logic [7:0] rdata_next;
    logic mode_ok;
    logic [7:0] pclk_period;
    logic [2:0] frame_octets;
    logic fixed_ok;
    logic [7:0] lane_en;
    logic [7:0] start_seen_reg;
    xport_pkg::deskew_state_t ds_reg;
    logic [3:0] lanes;
    logic [15:0] s0_reg, s1_reg;
    logic sv_out_reg;
    assign lanes = lane_setting_reg[`LANE_SETTING_MSB:`LANE_SETTING_LSB];
    mode_check u_mode (
        .interp(xport_pkg::interp_t'(interp_reg[2:0])),
        .lanes(lanes),
        .lanes_m1(l_m1_reg),
        .f_m1(f_m1_reg),
        .s_m1(sv_reg & 8'h1f),
        .hd(hd_reg),
        .mode_ok(mode_ok),
        .pclk_period(pclk_period),
        .frame_octets(frame_octets)
    );
    // fixed parameters and identifiers of version
    assign fixed_ok = (k_m1_reg[4:0] == 5'(`FIXED_K - 8'd1))
        && (m_m1_reg == `FIXED_M - 8'd1) && (n_m1_reg[4:0] == 5'(`FIXED_N - 8'd1))
        && (np_m1_reg[4:0] == 5'(`FIXED_NP - 8'd1))
        && (sv_reg[`VERSION_MSB:`VERSION_LSB] == `VERSION_B); // RULE_02 RULE_09
    assign config_valid = mode_ok && fixed_ok; // RULE_16
    // register writes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lane_setting_reg <= `RST_ZERO;
            powerdown_reg <= `RST_POWERDOWN; // RULE_13
            did_reg <= `RST_ZERO;
            bid_reg <= `RST_ZERO;
            lane_zero_identifier_reg <= `RST_ZERO;
            l_m1_reg <= `RST_ZERO;
            f_m1_reg <= `RST_ZERO;
            k_m1_reg <= `RST_ZERO;
            m_m1_reg <= `RST_ZERO;
            n_m1_reg <= `RST_ZERO;
            np_m1_reg <= `RST_ZERO;
            sv_reg <= `RST_ZERO;
            hd_reg <= `RST_ZERO;
            interp_reg <= `RST_ZERO;
        end else if (wr) begin
            if (addr == `OFF_LOGICAL_LANE_SETTING) lane_setting_reg <= wdata;
            else if (addr == `OFF_PHYSICAL_LANE_POWERDOWN) powerdown_reg <= wdata;
            else if (addr == `OFF_LINK_DEVICE_IDENTIFIER) did_reg <= wdata;
            else if (addr == `OFF_LINK_BANK_IDENTIFIER) bid_reg <= wdata;
            else if (addr == `OFF_LANE_ZERO_IDENTIFIER) lane_zero_identifier_reg <= wdata & 8'h1f;
            else if (addr == `OFF_LANE_COUNT_MINUS_ONE) l_m1_reg <= wdata & 8'h1f;
            else if (addr == `OFF_OCTETS_PER_FRAME_MINUS_ONE) f_m1_reg <= wdata;
            else if (addr == `OFF_FRAMES_PER_MULTIFRAME_MINUS_ONE) k_m1_reg <= wdata & 8'h1f;
            else if (addr == `OFF_CONVERTER_COUNT_MINUS_ONE) m_m1_reg <= wdata;
            else if (addr == `OFF_RESOLUTION_MINUS_ONE) n_m1_reg <= wdata & 8'h1f;
            else if (addr == `OFF_SAMPLE_BITS_MINUS_ONE) np_m1_reg <= wdata & 8'h1f;
            else if (addr == `OFF_SAMPLES_AND_VERSION) sv_reg <= wdata;
            else if (addr == `OFF_HIGH_DENSITY_FLAG) hd_reg <= wdata & 8'h80;
            else if (addr == `OFF_INTERP_SELECT) interp_reg <= wdata & 8'h07;
        end
    end
    // read decode, unmapped reads zero
    always_comb begin
        if (addr == `OFF_LOGICAL_LANE_SETTING) rdata_next = lane_setting_reg;
        else if (addr == `OFF_PHYSICAL_LANE_POWERDOWN) rdata_next = powerdown_reg;
        else if (addr == `OFF_LINK_DEVICE_IDENTIFIER) rdata_next = did_reg;
        else if (addr == `OFF_LINK_BANK_IDENTIFIER) rdata_next = bid_reg;
        else if (addr == `OFF_LANE_ZERO_IDENTIFIER) rdata_next = lane_zero_identifier_reg;
        else if (addr == `OFF_LANE_COUNT_MINUS_ONE) rdata_next = l_m1_reg;
        else if (addr == `OFF_OCTETS_PER_FRAME_MINUS_ONE) rdata_next = f_m1_reg;
        else if (addr == `OFF_FRAMES_PER_MULTIFRAME_MINUS_ONE) rdata_next = k_m1_reg;
        else if (addr == `OFF_CONVERTER_COUNT_MINUS_ONE) rdata_next = m_m1_reg;
        else if (addr == `OFF_RESOLUTION_MINUS_ONE) rdata_next = n_m1_reg;
        else if (addr == `OFF_SAMPLE_BITS_MINUS_ONE) rdata_next = np_m1_reg;
        else if (addr == `OFF_SAMPLES_AND_VERSION) rdata_next = sv_reg;
        else if (addr == `OFF_HIGH_DENSITY_FLAG) rdata_next = hd_reg;
        else if (addr == `OFF_INTERP_SELECT) rdata_next = interp_reg;
        else if (addr == `OFF_XPORT_STATUS)
            rdata_next = {3'd0, frame_octets, ds_reg == xport_pkg::DS_ALIGNED, config_valid};
        else if (addr == `OFF_PCLK_PERIOD) rdata_next = pclk_period; // RULE_04
        else rdata_next = 8'h00;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) rdata <= 8'h00;
        else if (rd) rdata <= rdata_next;
        else rdata <= 8'h00;
    end
    // logical lanes enabled by the lane setting once the setup is valid
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_en
            assign lane_en[gi] = (4'(gi) < lanes) && config_valid; // RULE_12
        end
    endgenerate
    assign link.lane_powerdown = powerdown_reg; // RULE_13
    assign link.link_ready = config_valid;
    // automatic deskew: wait for a start marker on every enabled lane
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ds_reg <= xport_pkg::DS_HUNT;
            start_seen_reg <= 8'h00;
        end else if (!config_valid) begin
            ds_reg <= xport_pkg::DS_HUNT;
            start_seen_reg <= 8'h00;
        end else begin
            case (ds_reg)
                xport_pkg::DS_HUNT: begin
                    start_seen_reg <= start_seen_reg | (link.lane_start & link.lane_valid);
                    if (((start_seen_reg | link.lane_start) & lane_en) == lane_en)
                        ds_reg <= xport_pkg::DS_ALIGNED; // RULE_11
                end
                default: ds_reg <= xport_pkg::DS_ALIGNED;
            endcase
        end
    end
    // deframer: lane 0 word carries octets, plus lane 1 for the second sample above one lane; two 16-bit samples per frame pair
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s0_reg <= 16'h0000;
            s1_reg <= 16'h0000;
            sv_out_reg <= 1'b0;
        end else if (ds_reg == xport_pkg::DS_ALIGNED && link.lane_valid[0]) begin
            // four octets per lane per cycle: samples msb octet first
            s0_reg <= link.lane_data[31:16]; // RULE_10 RULE_14 RULE_15
            s1_reg <= (lanes == 4'd1) ? link.lane_data[15:0] : link.lane_data[63:48];
            sv_out_reg <= 1'b1;
        end else begin
            sv_out_reg <= 1'b0;
        end
    end
    assign dac0_sample = s0_reg;
    assign dac1_sample = s1_reg;
    assign sample_valid = sv_out_reg;
endmodule

// ==== rtl/xport_tx.sv ====
`timescale 1ns/10ps
`include "xport_defines.svh"
// transmitter end: frames two converter samples onto the lanes
module xport_tx (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [15:0] conv0_sample,
    input wire logic [15:0] conv1_sample,
    input wire logic sample_en,
    output logic [7:0] powered_lanes,
    xport_link_if.transmitter link
);
    logic [7:0] valid_reg, start_reg;
    logic [255:0] data_reg;
    logic started_reg;
    // lanes stay quiet until the receiver reports a valid setup
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            valid_reg <= 8'h00;
            start_reg <= 8'h00;
            data_reg <= '0;
            started_reg <= 1'b0;
        end else if (link.link_ready && sample_en) begin
            valid_reg <= ~link.lane_powerdown;
            start_reg <= started_reg ? 8'h00 : ~link.lane_powerdown;
            started_reg <= 1'b1;
            // lanes 0 and 1: [31:16] and [63:48] carry the pair, [15:0] the second in 1-lane
            data_reg <= {192'd0, conv1_sample, conv0_sample, conv0_sample, conv1_sample}; // RULE_02
        end else begin
            valid_reg <= 8'h00;
            start_reg <= 8'h00;
            if (!link.link_ready) started_reg <= 1'b0;
        end
    end
    assign link.lane_valid = valid_reg;
    assign link.lane_start = start_reg;
    assign link.lane_data = data_reg;
    assign powered_lanes = ~link.lane_powerdown;
endmodule

// ==== bench/jesd_rx_transport_config_asserts.sv ====
`timescale 1ns/10ps
// watches the lane interface between the two ends
module jesd_rx_transport_config_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] lane_valid,
    input wire logic [7:0] lane_start,
    input wire logic [255:0] lane_data,
    input wire logic [7:0] lane_powerdown,
    input wire logic link_ready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // first word of a burst, and the edge after reset release
    sequence s_burst_start; $rose(lane_valid != 8'h00); endsequence
    sequence s_released; $fell(rst); endsequence
    // properties
    property p_pd_reset; s_released |-> lane_powerdown == 8'h00; endproperty
    property p_ready_reset; s_released |-> !link_ready; endproperty
    property p_valid_reset;
        s_released |-> lane_valid == 8'h00 ##1 lane_valid == 8'h00;
    endproperty
    property p_valid_needs_ready; lane_valid != 8'h00 |-> $past(link_ready); endproperty
    property p_ready_drop; $fell(link_ready) |=> lane_valid == 8'h00; endproperty
    property p_start_in_valid; (lane_start & ~lane_valid) == 8'h00; endproperty
    property p_pd_quiet;
        (lane_valid & lane_powerdown & $past(lane_powerdown)) == 8'h00;
    endproperty
    property p_first_start; s_burst_start |-> lane_start == lane_valid; endproperty
    a_pd_reset: assert property (p_pd_reset) else $error("powerdown not clear");
    a_ready_reset: assert property (p_ready_reset) else $error("ready after reset");
    a_valid_reset: assert property (p_valid_reset) else $error("lanes busy early");
    a_valid_needs_ready: assert property (p_valid_needs_ready) else $error("no ready");
    a_ready_drop: assert property (p_ready_drop) else $error("lanes after drop");
    a_start_in_valid: assert property (p_start_in_valid) else $error("start idle");
    a_pd_quiet: assert property (p_pd_quiet) else $error("off lane active");
    a_first_start: assert property (p_first_start) else $error("no start mark");
endmodule

// ==== bench/jesd_rx_transport_config_tb_top.sv ====
`timescale 1ns/10ps
module jesd_rx_transport_config_tb_top;
    typedef struct {logic [3:0] l; logic [7:0] f; logic [7:0] s; int min_i;} row_t;
    // lane count, octets per frame, samples per frame, index of the lowest legal interpolation factor
    row_t rows [6] = '{'{4'h8, 8'h1, 8'h2, 0}, '{4'h6, 8'h2, 8'h3, 0},
        '{4'h4, 8'h1, 8'h1, 0}, '{4'h3, 8'h4, 8'h3, 0}, '{4'h2, 8'h2, 8'h1, 1},
        '{4'h1, 8'h4, 8'h1, 3}};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [15:0] dac0_sample;
    logic [15:0] dac1_sample;
    logic sample_valid;
    logic config_valid;
    logic [15:0] conv0_sample = 16'h1234;
    logic [15:0] conv1_sample = 16'hbeef;
    logic sample_en = 1'b0;
    logic [7:0] powered_lanes;
    logic [7:0] v;
    int fac [5] = '{6, 8, 12, 16, 24};
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int k;
    xport_link_if link_if ();
    xport_rx xport_rx_inst (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .dac0_sample(dac0_sample), .dac1_sample(dac1_sample),
        .sample_valid(sample_valid), .config_valid(config_valid), .link(link_if.receiver));
    xport_tx xport_tx_inst (.mclk(mclk), .rst(rst), .conv0_sample(conv0_sample),
        .conv1_sample(conv1_sample), .sample_en(sample_en), .powered_lanes(powered_lanes),
        .link(link_if.transmitter));
    jesd_rx_transport_config_asserts jesd_rx_transport_config_asserts_inst (.mclk(mclk),
        .rst(rst), .lane_valid(link_if.lane_valid), .lane_start(link_if.lane_start),
        .lane_data(link_if.lane_data), .lane_powerdown(link_if.lane_powerdown),
        .link_ready(link_if.link_ready));
    // clock and cycle ceiling
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle register strobes
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // full link setup written as value minus one
    task automatic cfg(input logic [2:0] i, input row_t r, input logic [7:0] km1,
        input logic [2:0] ver, input logic hd);
        wr_reg(12'h110, {r.l, 4'h0});
        wr_reg(12'h453, {4'h0, r.l} - 8'h01);
        wr_reg(12'h454, r.f - 8'h01);
        wr_reg(12'h455, km1);
        wr_reg(12'h456, 8'h01);
        wr_reg(12'h457, 8'h0f);
        wr_reg(12'h458, 8'h0f);
        wr_reg(12'h459, {ver, 5'(r.s - 8'h01)});
        wr_reg(12'h45a, {hd, 7'h00});
        wr_reg(12'h460, {5'h00, i});
    endtask
    task automatic status(input logic exp);
        rd_reg(12'h461, v);
        chk("config status", {15'h0000, exp}, {15'h0000, v[0]});
        chk("config port", {15'h0000, exp}, {15'h0000, config_valid});
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(12'h201, v);
        chk("powerdown reset", 16'h0000, {8'h00, v});
        chk("powerdown pins", 16'h0000, {8'h00, link_if.lane_powerdown});
        // every interpolation against every lane count
        foreach (rows[r]) begin
            for (k = 0; k < 5; k++) begin
                cfg(3'(k), rows[r], 8'h1f, 3'h1, rows[r].f == 8'h01);
                status(k >= rows[r].min_i);
                chk("frame octets", {13'h0000, rows[r].f[2:0]}, {13'h0000, v[4:2]});
                rd_reg(12'h462, v);
                chk("pclk period", 16'(fac[k] * rows[r].l), {8'h00, v});
            end
        end
        // broken settings on a legal mode
        cfg(3'h3, rows[0], 8'h1f, 3'h1, 1'b0);
        status(1'b0);
        cfg(3'h3, rows[0], 8'h1f, 3'h0, 1'b1);
        status(1'b0);
        cfg(3'h3, rows[0], 8'h1e, 3'h1, 1'b1);
        status(1'b0);
        // identifiers kept, lane zero id five bits wide, unmapped space reads zero
        wr_reg(12'h450, 8'ha5);
        wr_reg(12'h451, 8'h5a);
        wr_reg(12'h452, 8'hff);
        rd_reg(12'h450, v);
        chk("device id", 16'h00a5, {8'h00, v});
        rd_reg(12'h451, v);
        chk("bank id", 16'h005a, {8'h00, v});
        rd_reg(12'h452, v);
        chk("lane zero id", 16'h001f, {8'h00, v});
        rd_reg(12'h7ff, v);
        chk("unmapped", 16'h0000, {8'h00, v});
        wr_reg(12'h201, 8'hc3);
        #1;
        chk("powerdown pins", 16'h00c3, {8'h00, link_if.lane_powerdown});
        wr_reg(12'h201, 8'h00);
        // live traffic in eight-lane mode
        cfg(3'h3, rows[0], 8'h1f, 3'h1, 1'b1);
        status(1'b1);
        @(posedge mclk);
        sample_en <= 1'b1;
        k = 0;
        while (sample_valid !== 1'b1 && k < 200) begin
            @(posedge mclk);
            #1 k++;
        end
        chk("sample seen", 16'h0001, {15'h0000, sample_valid});
        chk("dac0", 16'h1234, dac0_sample);
        chk("dac1", 16'hbeef, dac1_sample);
        rd_reg(12'h461, v);
        chk("aligned", 16'h0001, {15'h0000, v[1]});
        // powering lanes down in traffic silences exactly those lanes
        wr_reg(12'h201, 8'hc0);
        repeat (2) @(posedge mclk);
        #1;
        chk("lanes after powerdown", 16'h003f, {8'h00, link_if.lane_valid});
        chk("powered lanes", 16'h003f, {8'h00, powered_lanes});
        @(posedge mclk);
        sample_en <= 1'b0;
        wr_reg(12'h455, 8'h00);
        repeat (3) @(posedge mclk);
        #1;
        chk("lanes idle", 16'h0000, {8'h00, link_if.lane_valid});
        // reset in mid-run clears the setup and powers every lane up
        @(posedge mclk);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(12'h201, v);
        chk("powerdown after reset", 16'h0000, {8'h00, v});
        rd_reg(12'h461, v);
        chk("status after reset", 16'h0000, {8'h00, v});
        close_out();
    end
endmodule
